// ==== hw/usbtc_pkg.sv ====
/*
  Shared constants and carrier types for the termination and line control block.
  Assumes a single 200 MHz clock and link control fields already held stable by the caller.
*/
package usbtc_pkg;

  // ==========================================================
  // Field encodings
  localparam logic [1:0] XS_HIGH_SPEED = 2'h0; // Select code for HS path
  localparam logic [1:0] OM_NORMAL = 2'h0; // Normal operation
  localparam logic [1:0] OM_NON_DRIVE = 2'h1; // Drivers off
  localparam logic [1:0] OM_RAW = 2'h2; // No stuffing, no NRZI

  // ==========================================================
  // Widths and analog code defaults
  localparam int LEVEL_W = 4; // Width of level codes
  localparam int BOOST_W = 3; // Amplitude boost field
  localparam int SENS_W = 2; // Squelch sensitivity field
  localparam logic [LEVEL_W-1:0] AMP_BASE = 4'h8; // Unboosted amplitude code
  localparam logic [LEVEL_W-1:0] SQ_BASE = 4'h8; // Nominal squelch code

  // ==========================================================
  // Serializer constants
  localparam logic [2:0] STUFF_RUN = 3'h6; // Ones before a stuffed zero
  localparam logic [2:0] LAST_BIT = 3'h7; // Index of final byte bit
  localparam logic [2:0] ZERO3 = 3'h0; // Counter clear value
  localparam logic [2:0] ONE3 = 3'h1; // Counter step
  localparam logic IDLE_LEVEL = 1'b1; // J level on an idle line
  localparam logic [1:0] SE0_STATE = 2'h0; // Line state after reset

  // ==========================================================
  // Carrier types
  typedef struct packed {
    logic [1:0] transceiver_speed_select; // Speed select
    logic termination_select; // Termination select
    logic [1:0] operating_mode_field; // Operating mode
    logic plus_line_low_pull_request; // Plus pull-down request
    logic minus_line_low_pull_request; // Minus pull-down request
  } usbtc_ctrl_s;

  typedef struct packed {
    logic [BOOST_W-1:0] tx_amplitude_boost; // Amplitude step
    logic [SENS_W-1:0] squelch_sensitivity; // Squelch step down
  } usbtc_comp_s;

  typedef struct packed {
    logic plus_line_high_res_on; // Plus 1.5k pull-up
    logic minus_line_high_res_on; // Minus 1.5k pull-up
    logic plus_line_low_res_on; // Plus 15k pull-down
    logic minus_line_low_res_on; // Minus 15k pull-down
    logic fast_termination_on; // 45 ohm on both lines
  } usbtc_term_s;

  localparam usbtc_term_s TERM_OFF = 5'h00; // Every resistor off
  localparam usbtc_term_s TERM_PD = 5'h06; // Both pull-downs
  localparam usbtc_term_s TERM_PD_HS = 5'h07; // Pull-downs and 45 ohm
  localparam usbtc_term_s TERM_PU_P = 5'h10; // Plus pull-up
  localparam usbtc_term_s TERM_PU_M = 5'h08; // Minus pull-up
  localparam usbtc_term_s TERM_HS = 5'h01; // 45 ohm only
  localparam usbtc_term_s TERM_PU_P_PD_M = 5'h12; // Plus up, minus down
  localparam usbtc_term_s TERM_PD_M_HS = 5'h03; // Minus down, 45 ohm
  localparam usbtc_term_s TERM_PD_M = 5'h02; // Minus down only
  localparam usbtc_term_s TERM_FALLBACK = TERM_PD; // Undefined combos

  typedef enum logic {TX_IDLE, TX_SHIFT} usbtc_tx_e;

endpackage

// ==== hw/usbtc_term_dec.sv ====
/*
  Combinational decode of link control fields into resistor enables.
  Assumes the caller registers the result so that no glitch reaches a pin.
*/
`timescale 1ns/10ps
module usbtc_term_dec (
  input wire usbtc_pkg::usbtc_ctrl_s ctrl_i,
  output usbtc_pkg::usbtc_term_s term_o
);
  import usbtc_pkg::*;

  // ==========================================================
  // Table decode
  // Key order: select[1:0], term, mode[1:0], plus req, minus req
  always_comb begin
    term_o = TERM_FALLBACK; // Anything undefined
    if (ctrl_i.operating_mode_field == OM_NON_DRIVE) begin
      term_o = TERM_OFF; // Non-driving wins over all
    end else begin
      casez (ctrl_i)
        7'b01_0_00_11: term_o = TERM_PD; // Power-up
        7'b00_0_10_11: term_o = TERM_PD_HS; // Host chirp
        7'b00_0_00_11: term_o = TERM_PD_HS; // Host HS
        7'b?1_1_00_11: term_o = TERM_PD; // Host FS, suspend
        7'b01_1_10_11: term_o = TERM_PD; // Host resume
        7'b10_1_00_11: term_o = TERM_PD; // Host LS
        7'b10_1_10_11: term_o = TERM_PD; // Host LS resume
        7'b00_1_10_00: term_o = TERM_PU_P; // Peripheral chirp
        7'b00_0_00_00: term_o = TERM_HS; // Peripheral HS
        7'b01_1_00_00: term_o = TERM_PU_P; // Peripheral FS
        7'b01_1_10_00: term_o = TERM_PU_P; // Peripheral resume
        7'b10_1_00_00: term_o = TERM_PU_M; // Peripheral LS
        7'b10_1_10_00: term_o = TERM_PU_M; // Peripheral LS resume
        7'b00_0_10_00: term_o = TERM_HS; // Peripheral test J/K
        7'b00_1_10_01: term_o = TERM_PU_P_PD_M; // OTG chirp
        7'b00_0_00_01: term_o = TERM_PD_M_HS; // OTG HS
        7'b01_1_00_01: term_o = TERM_PU_P_PD_M; // OTG FS
        7'b01_1_10_01: term_o = TERM_PU_P_PD_M; // OTG resume
        7'b00_0_10_01: term_o = TERM_PD_M_HS; // OTG test J/K
        7'b01_0_00_01: term_o = TERM_PD_M; // Connect detect
        default: term_o = TERM_FALLBACK; // Undefined
      endcase
    end
  end

endmodule

// ==== hw/usbtc_top.sv ====
/*
  Transceiver control: receive path select, squelch gating, line state,
  transmit encoder and serializer, amplitude and squelch trim, and the
  registered termination resistor enables.
  Assumes all inputs are synchronous to clk_i; analog receivers and
  drivers sit outside and see only these digital codes and enables.
*/
`timescale 1ns/10ps
module usbtc_top (
  input wire logic clk_i, // 200 MHz clock
  input wire logic srst_i, // Synchronous reset, active high
  input wire logic chip_reset_n_i, // Chip reset pin, active low
  input wire usbtc_pkg::usbtc_ctrl_s ctrl_i, // Link control fields
  input wire usbtc_pkg::usbtc_comp_s comp_i, // Compensation fields
  input wire logic hs_rx_bit_i, // HS differential receiver
  input wire logic fs_rx_bit_i, // FS/LS differential receiver
  input wire logic [usbtc_pkg::LEVEL_W-1:0] hs_rx_level_i, // HS amplitude
  input wire logic se_plus_i, // Plus-line single-ended rx
  input wire logic se_minus_i, // Minus-line single-ended rx
  input wire logic [7:0] tx_data_i, // Byte from link
  input wire logic tx_valid_i, // Byte offered
  output logic tx_ready_o, // Byte accepted when valid
  output usbtc_pkg::usbtc_term_s term_o, // Resistor enables
  output logic rx_bit_o, // Selected receive bit
  output logic squelch_open_o, // HS signal above threshold
  output logic [1:0] line_state_o, // {minus, plus}
  output logic [usbtc_pkg::LEVEL_W-1:0] sq_threshold_o, // Squelch code
  output logic [usbtc_pkg::LEVEL_W-1:0] hs_tx_level_o, // HS amplitude
  output logic hs_tx_bit_o, // HS transmit bit
  output logic hs_tx_oe_n_o, // HS driver enable, low drives
  output logic fs_tx_bit_o, // FS/LS transmit bit
  output logic fs_tx_oe_n_o // FS driver enable, low drives
);
  import usbtc_pkg::*;

  // ==========================================================
  // Mode decode
  logic hs_mode; // HS path selected
  logic raw_mode; // Stuffing and NRZI bypassed
  logic drivers_off; // Chip reset or non-driving mode
  usbtc_term_s term_nxt; // Decoded enables

  assign hs_mode = (ctrl_i.transceiver_speed_select == XS_HIGH_SPEED);
  assign raw_mode = (ctrl_i.operating_mode_field == OM_RAW);
  // Chip reset and non-driving mode both float the drivers
  assign drivers_off = !chip_reset_n_i ||
    (ctrl_i.operating_mode_field == OM_NON_DRIVE);

  // ==========================================================
  // Termination decode
  usbtc_term_dec u_term_dec (
    .ctrl_i(ctrl_i),
    .term_o(term_nxt)
  );

  // Registered so table transitions never glitch a resistor
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      term_o <= TERM_FALLBACK; // Safe pull-downs from reset
    end else if (!chip_reset_n_i) begin
      // Pull-ups and pull-downs still decoded; 45 ohm released
      term_o <= term_nxt;
      term_o.fast_termination_on <= 1'b0;
    end else begin
      term_o <= term_nxt; // One edge after a field change
    end
  end

  // ==========================================================
  // Squelch threshold and transmit amplitude
  // Threshold only moves down; a large step saturates at zero
  logic [LEVEL_W-1:0] sq_nxt; // Trimmed threshold
  logic [LEVEL_W-1:0] amp_nxt; // Boosted amplitude
  logic [LEVEL_W:0] amp_sum; // Sum with carry

  always_comb begin
    if (SQ_BASE > LEVEL_W'(comp_i.squelch_sensitivity)) begin
      sq_nxt = SQ_BASE - LEVEL_W'(comp_i.squelch_sensitivity);
    end else begin
      sq_nxt = '0; // Floor
    end
  end

  assign amp_sum = {1'b0, AMP_BASE} + (LEVEL_W+1)'(comp_i.tx_amplitude_boost);
  // Saturate rather than wrap so boost never shrinks the swing
  assign amp_nxt = amp_sum[LEVEL_W] ? '1 : amp_sum[LEVEL_W-1:0];

  // Trim codes registered for the analog side
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      sq_threshold_o <= SQ_BASE;
      hs_tx_level_o <= AMP_BASE;
    end else begin
      sq_threshold_o <= sq_nxt;
      hs_tx_level_o <= amp_nxt;
    end
  end

  // ==========================================================
  // Receive path
  logic sq_open_nxt; // Signal clears threshold

  // Compare against the live threshold, not the registered copy
  assign sq_open_nxt = (hs_rx_level_i > sq_nxt);

  // Squelch flag follows the detector in HS mode, held low otherwise
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      squelch_open_o <= 1'b0;
    end else begin
      squelch_open_o <= sq_open_nxt && hs_mode;
    end
  end

  // Receive multiplexer
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      rx_bit_o <= 1'b0;
    end else if (hs_mode) begin
      // Noise under threshold never reaches the receive logic
      rx_bit_o <= hs_rx_bit_i && sq_open_nxt;
    end else begin
      rx_bit_o <= fs_rx_bit_i; // FS/LS path
    end
  end

  // Line state from the single-ended receivers only
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      line_state_o <= SE0_STATE;
    end else begin
      line_state_o <= {se_minus_i, se_plus_i};
    end
  end

  // ==========================================================
  // Transmit serializer
  usbtc_tx_e tx_state_r; // Serializer state
  logic [7:0] shift_r; // Byte being sent, LSB first
  logic [2:0] bit_cnt_r; // Bit index in byte
  logic [2:0] ones_r; // Run of ones since last zero
  logic line_r; // Encoded line level
  logic raw_r; // Raw mode latched per byte
  logic take; // Byte handshake
  logic stuff_now; // Stuffed bit this cycle
  logic last_now; // Final data bit this cycle

  assign take = tx_valid_i && tx_ready_o;
  assign stuff_now = !raw_r && (ones_r == STUFF_RUN);
  assign last_now = !stuff_now && (bit_cnt_r == LAST_BIT);

  // State and handshake
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      tx_state_r <= TX_IDLE;
      tx_ready_o <= 1'b1;
    end else begin
      unique case (tx_state_r)
        TX_IDLE: begin
          if (take) begin
            tx_state_r <= TX_SHIFT;
            tx_ready_o <= 1'b0;
          end
        end
        TX_SHIFT: begin
          if (last_now) begin
            tx_state_r <= TX_IDLE;
            tx_ready_o <= 1'b1; // Next byte may follow at once
          end
        end
      endcase
    end
  end

  // Shift register and bit index
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      shift_r <= '0;
      bit_cnt_r <= ZERO3;
      raw_r <= 1'b0;
    end else if (take) begin
      shift_r <= tx_data_i; // Serialize
      bit_cnt_r <= ZERO3;
      raw_r <= raw_mode;
    end else if (tx_state_r == TX_SHIFT && !stuff_now) begin
      shift_r <= {1'b0, shift_r[7:1]}; // Hold during a stuffed bit
      bit_cnt_r <= bit_cnt_r + ONE3;
    end
  end

  // Bit stuffing run counter
  // Run carries across bytes so stuffing spans byte edges
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      ones_r <= ZERO3;
    end else if (tx_state_r == TX_SHIFT) begin
      if (stuff_now || !shift_r[0]) begin
        ones_r <= ZERO3;
      end else begin
        ones_r <= ones_r + ONE3;
      end
    end else if (!tx_valid_i) begin
      ones_r <= ZERO3; // Gap ends the packet
    end
  end

  // NRZI encoder: a zero toggles, a one holds
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      line_r <= IDLE_LEVEL;
    end else if (tx_state_r == TX_SHIFT) begin
      if (stuff_now) begin
        line_r <= !line_r; // Stuffed zero
      end else if (raw_r) begin
        line_r <= shift_r[0]; // Raw chirp or test pattern
      end else if (!shift_r[0]) begin
        line_r <= !line_r; // Encoded zero
      end
    end else if (!tx_valid_i) begin
      line_r <= IDLE_LEVEL; // Back to J between packets
    end
  end

  // ==========================================================
  // Transmitter drive
  logic tx_active; // Serializer busy
  logic line_on_r; // line_r holds a data or stuffed bit

  assign tx_active = (tx_state_r == TX_SHIFT);

  // Drive window trails the state by one edge so it frames line_r exactly;
  // keying it off the state directly would drop the last bit of every byte
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      line_on_r <= 1'b0;
    end else begin
      line_on_r <= tx_active;
    end
  end

  // HS transmitter: floated by chip reset or non-driving mode
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      hs_tx_bit_o <= IDLE_LEVEL;
      hs_tx_oe_n_o <= 1'b1;
    end else begin
      hs_tx_bit_o <= line_r;
      hs_tx_oe_n_o <= !(line_on_r && hs_mode) || drivers_off;
    end
  end

  // FS/LS transmitter
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      fs_tx_bit_o <= IDLE_LEVEL;
      fs_tx_oe_n_o <= 1'b1;
    end else begin
      fs_tx_bit_o <= line_r;
      fs_tx_oe_n_o <= !(line_on_r && !hs_mode) || drivers_off;
    end
  end

endmodule

// ==== dv/usbtc_link_model.sv ====
/*
  Link-side byte source for the transmit handshake.
  Assumes the bench pushes bytes into fifo away from the rising edge.
*/
`timescale 1ns/10ps
module usbtc_link_model (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic tx_ready_i,
  output logic [7:0] tx_data_o,
  output logic tx_valid_o
);
  // ==========================================
  // Byte queue and offer
  logic [7:0] fifo[$]; // Bytes waiting to go out
  initial begin
    tx_data_o = 8'h5a;
    tx_valid_o = 1'b0;
  end
  // Offer held until taken; idle data churns so nothing stale looks valid
  always @(posedge clk_i) begin
    if (srst_i) begin
      tx_valid_o <= 1'b0;
    end else if (!tx_valid_o || tx_ready_i) begin
      if (fifo.size() > 0) begin
        tx_data_o <= fifo.pop_front();
        tx_valid_o <= 1'b1;
      end else begin
        tx_data_o <= ~tx_data_o;
        tx_valid_o <= 1'b0;
      end
    end
  end
endmodule

// ==== dv/usbtc_properties.sv ====
/*
  Checker for the termination and line control block.
  Assumes it is bound to usbtc_top and sees only its ports.
*/
`timescale 1ns/10ps
module usbtc_properties
  import usbtc_pkg::*;
(
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic chip_reset_n_i,
  input wire usbtc_pkg::usbtc_ctrl_s ctrl_i,
  input wire usbtc_pkg::usbtc_comp_s comp_i,
  input wire logic fs_rx_bit_i,
  input wire logic [usbtc_pkg::LEVEL_W-1:0] hs_rx_level_i,
  input wire logic se_plus_i,
  input wire logic se_minus_i,
  input wire logic tx_valid_i,
  input wire logic tx_ready_o,
  input wire usbtc_pkg::usbtc_term_s term_o,
  input wire logic rx_bit_o,
  input wire logic squelch_open_o,
  input wire logic [1:0] line_state_o,
  input wire logic [usbtc_pkg::LEVEL_W-1:0] sq_threshold_o,
  input wire logic [usbtc_pkg::LEVEL_W-1:0] hs_tx_level_o,
  input wire logic hs_tx_oe_n_o,
  input wire logic fs_tx_oe_n_o
);
  // ==========================================
  // Termination decode, one edge after the fields
  default clocking @(posedge clk_i); endclocking
  default disable iff (srst_i);
  AST_NON_DRIVE: assert property (ctrl_i.operating_mode_field == OM_NON_DRIVE
    |=> term_o == TERM_OFF) else $error("terminations not all off");
  AST_POWER_UP: assert property (ctrl_i == 7'h23 |=> term_o == TERM_PD)
    else $error("power-up terminations wrong");
  AST_HOST_HS: assert property (ctrl_i inside {7'h0b, 7'h03} && chip_reset_n_i
    |=> term_o == TERM_PD_HS) else $error("host chirp or HS terminations wrong");
  AST_PD_ONLY: assert property (ctrl_i inside {7'h33, 7'h73, 7'h3b, 7'h53}
    |=> term_o == TERM_PD) else $error("pull-down only setting wrong");
  AST_OTG_CHIRP: assert property (ctrl_i == 7'h19 |=> term_o == TERM_PU_P_PD_M)
    else $error("OTG chirp terminations wrong");
  AST_OTG_HS: assert property (ctrl_i == 7'h01 && chip_reset_n_i
    |=> term_o == TERM_PD_M_HS) else $error("OTG HS terminations wrong");
  AST_FALLBACK: assert property (ctrl_i.transceiver_speed_select == 2'h3
    && !ctrl_i.termination_select && ctrl_i.operating_mode_field != OM_NON_DRIVE
    |=> term_o == TERM_FALLBACK) else $error("fallback terminations wrong");
  AST_CHIP_RESET: assert property (!chip_reset_n_i |=> !term_o.fast_termination_on)
    else $error("45 ohm enabled in chip reset");
  // Reset release excluded: first edge loads the decode over the reset value
  AST_HOLD: assert property (!$past(srst_i) && $stable(ctrl_i) && $stable(chip_reset_n_i)
    |=> $stable(term_o)) else $error("terminations moved without cause");
  // ==========================================
  // Receive path, trim, transmit handshake and driver float
  AST_SQUELCH: assert property (ctrl_i.transceiver_speed_select == XS_HIGH_SPEED
    && hs_rx_level_i <= SQ_BASE - comp_i.squelch_sensitivity
    |=> !rx_bit_o && !squelch_open_o) else $error("noise passed squelch");
  AST_FS_PATH: assert property (ctrl_i.transceiver_speed_select != XS_HIGH_SPEED
    |=> rx_bit_o == $past(fs_rx_bit_i)) else $error("FS receive bit not routed");
  AST_LINE: assert property (1'b1 |=> line_state_o[0] == $past(se_plus_i)
    && line_state_o[1] == $past(se_minus_i)) else $error("line state wrong");
  AST_TRIM: assert property (1'b1
    |=> sq_threshold_o == SQ_BASE - $past(comp_i.squelch_sensitivity)
    && hs_tx_level_o == AMP_BASE + $past(comp_i.tx_amplitude_boost))
    else $error("trim codes wrong");
  AST_TX_TAKE: assert property (tx_valid_i && tx_ready_o |=> !tx_ready_o)
    else $error("ready stayed high after take");
  AST_DRIVERS_OFF: assert property (!chip_reset_n_i
    || ctrl_i.operating_mode_field == OM_NON_DRIVE |=> hs_tx_oe_n_o && fs_tx_oe_n_o)
    else $error("driver enabled while floated");
  // ==========================================
  // Main scenarios seen
  COV_OTG_CHIRP: cover property (ctrl_i == 7'h19 ##1 term_o == TERM_PU_P_PD_M);
  COV_TX_TAKE: cover property (tx_valid_i && tx_ready_o);
  COV_SQ_OPEN: cover property (squelch_open_o && rx_bit_o);
endmodule

// ==== dv/usbtc_top_tb.sv ====
/*
  Self-checking bench for usbtc_top with a link byte source.
  Assumes usbtc_pkg, the design and the checker are compiled first.
*/
`timescale 1ns/10ps
module usbtc_top_tb;
  import usbtc_pkg::*;
  // ==========================================
  // Stimulus and outputs
  logic clk_i = 1'b0, srst_i = 1'b1, chip_reset_n_i = 1'b1;
  usbtc_ctrl_s ctrl_i = 7'h23;
  usbtc_comp_s comp_i = 5'h00;
  logic hs_rx_bit_i = 1'b0, fs_rx_bit_i = 1'b0, se_plus_i = 1'b0, se_minus_i = 1'b0;
  logic [3:0] hs_rx_level_i = 4'h0, sq_threshold_o, hs_tx_level_o;
  logic [7:0] tx_data;
  logic tx_valid, tx_ready_o, rx_bit_o, squelch_open_o, hs_tx_bit_o, hs_tx_oe_n_o;
  logic fs_tx_bit_o, fs_tx_oe_n_o;
  logic [1:0] line_state_o;
  usbtc_term_s term_o;
  int n_fail = 0, comparisons = 0, cyc = 0;
  int qt[$]; // Check stamp of each note
  usbtc_term_s qv[$]; // Expected enables
  logic [11:0] qr[$]; // Expected receive and trim sample
  logic qx[$]; // Expected line levels while driving
  logic [31:0] seed = 32'h00001fe1; // Fixed start for repeatable runs
  // Table of settings, two of them undefined (7'h63, 7'h13), and their enables
  logic [6:0] tc[13] = '{7'h23, 7'h0b, 7'h03, 7'h33, 7'h73, 7'h3b, 7'h53,
                         7'h19, 7'h01, 7'h63, 7'h13, 7'h27, 7'h75};
  logic [4:0] te[13] = '{5'h06, 5'h07, 5'h07, 5'h06, 5'h06, 5'h06, 5'h06,
                         5'h12, 5'h03, 5'h06, 5'h06, 5'h00, 5'h00};
  usbtc_top i_dut (.clk_i(clk_i), .srst_i(srst_i), .chip_reset_n_i(chip_reset_n_i),
    .ctrl_i(ctrl_i), .comp_i(comp_i), .hs_rx_bit_i(hs_rx_bit_i), .fs_rx_bit_i(fs_rx_bit_i),
    .hs_rx_level_i(hs_rx_level_i), .se_plus_i(se_plus_i), .se_minus_i(se_minus_i),
    .tx_data_i(tx_data), .tx_valid_i(tx_valid), .tx_ready_o(tx_ready_o), .term_o(term_o),
    .rx_bit_o(rx_bit_o), .squelch_open_o(squelch_open_o), .line_state_o(line_state_o),
    .sq_threshold_o(sq_threshold_o), .hs_tx_level_o(hs_tx_level_o),
    .hs_tx_bit_o(hs_tx_bit_o), .hs_tx_oe_n_o(hs_tx_oe_n_o), .fs_tx_bit_o(fs_tx_bit_o),
    .fs_tx_oe_n_o(fs_tx_oe_n_o));
  usbtc_link_model i_link (.clk_i(clk_i), .srst_i(srst_i), .tx_ready_i(tx_ready_o),
    .tx_data_o(tx_data), .tx_valid_o(tx_valid));
  initial forever #2.5 clk_i = ~clk_i;
  // ==========================================
  // Helpers
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic cmp_term(input usbtc_term_s e, input usbtc_term_s g);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %0t term exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic cmp_rx(input logic [11:0] e, input logic [11:0] g);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %0t rx exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic cmp_tx(input logic e, input logic g);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %0t tx exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic end_sim();
    $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // One cycle of fields plus random receive inputs, with notes for both results
  task automatic step(input usbtc_ctrl_s c, input usbtc_term_s e, input logic n);
    logic [31:0] r;
    logic [3:0] thr;
    logic op;
    r = rnd();
    thr = SQ_BASE - r[1:0];
    op = c.transceiver_speed_select == XS_HIGH_SPEED && r[12:9] > thr;
    @(posedge clk_i);
    ctrl_i <= c;
    chip_reset_n_i <= n;
    comp_i <= r[4:0];
    {se_minus_i, se_plus_i, fs_rx_bit_i, hs_rx_bit_i} <= r[8:5];
    hs_rx_level_i <= r[12:9];
    qt.push_back(cyc + 2);
    qv.push_back(n ? e : e & 5'h1e);
    qr.push_back({op ? r[5] : (c.transceiver_speed_select != XS_HIGH_SPEED && r[6]), op,
      r[8:7], thr, AMP_BASE + r[4:2]});
  endtask
  // ==========================================
  // Result watcher and hang limit
  always @(negedge clk_i) begin
    cyc++;
    while (qt.size() > 0 && qt[0] == cyc) begin
      void'(qt.pop_front());
      cmp_term(qv.pop_front(), term_o);
      cmp_rx(qr.pop_front(), {rx_bit_o, squelch_open_o, line_state_o, sq_threshold_o,
        hs_tx_level_o});
    end
    if (hs_tx_oe_n_o === 1'b0) cmp_tx(qx.size() > 0 ? qx.pop_front() : 1'bx, hs_tx_bit_o);
    if (fs_tx_oe_n_o === 1'b0) cmp_tx(qx.size() > 0 ? qx.pop_front() : 1'bx, fs_tx_bit_o);
    if (cyc >= 2000) begin
      n_fail++;
      end_sim();
    end
  end
  // ==========================================
  // Main sequence
  initial begin
    logic [31:0] r;
    usbtc_ctrl_s c;
    logic [23:0] bits;
    logic lvl;
    int run;
    repeat (2) @(posedge clk_i);
    @(negedge clk_i);
    cmp_term(TERM_FALLBACK, term_o);
    @(posedge clk_i);
    srst_i <= 1'b0;
    // Whole table back to back, chip reset off then on
    for (int p = 0; p < 2; p++)
      for (int i = 0; i < 13; i++)
        step(tc[i], te[i], p == 0);
    for (int i = 0; i < 8; i++) begin
      r = rnd();
      c = r[6:0];
      c.operating_mode_field = OM_NON_DRIVE;
      step(c, TERM_OFF, r[7]);
    end
    // Three bytes per pass in HS, FS, then raw HS; long ones runs force stuffed toggles
    for (int p = 0; p < 3; p++) begin
      c = (p == 1) ? 7'h33 : ((p == 2) ? 7'h0b : 7'h03);
      step(c, (p == 1) ? TERM_PD : TERM_PD_HS, 1'b1);
      r = rnd();
      bits = {r[7:0] & 8'h7f, 8'hff, 8'hff};
      lvl = IDLE_LEVEL;
      run = 0;
      for (int i = 0; i < 24; i++) begin
        if (p == 2) lvl = bits[i]; // Raw: no NRZI, no stuffing
        else if (bits[i]) run++;
        else begin
          lvl = ~lvl;
          run = 0;
        end
        qx.push_back(lvl);
        if (run == 6) begin
          lvl = ~lvl;
          run = 0;
          qx.push_back(lvl);
        end
      end
      @(negedge clk_i);
      for (int i = 0; i < 3; i++) i_link.fifo.push_back(bits[8*i +: 8]);
      for (int k = 0; k < 200 && (qx.size() > 0 || !tx_ready_o); k++) @(posedge clk_i);
      repeat (4) @(posedge clk_i);
      cmp_tx(1'b0, logic'(qx.size() != 0));
    end
    end_sim();
  end
endmodule
bind usbtc_top usbtc_properties i_props (.clk_i(clk_i), .srst_i(srst_i),
  .chip_reset_n_i(chip_reset_n_i), .ctrl_i(ctrl_i), .comp_i(comp_i),
  .fs_rx_bit_i(fs_rx_bit_i), .hs_rx_level_i(hs_rx_level_i), .se_plus_i(se_plus_i),
  .se_minus_i(se_minus_i), .tx_valid_i(tx_valid_i), .tx_ready_o(tx_ready_o),
  .term_o(term_o), .rx_bit_o(rx_bit_o), .squelch_open_o(squelch_open_o),
  .line_state_o(line_state_o), .sq_threshold_o(sq_threshold_o),
  .hs_tx_level_o(hs_tx_level_o), .hs_tx_oe_n_o(hs_tx_oe_n_o), .fs_tx_oe_n_o(fs_tx_oe_n_o));
